// file: inc/flash_array_pkg.sv
package flash_array_pkg;
   // Register byte addresses on the Avalon-MM word bus
   localparam logic [3:0] array_select_addr  = 4'h0;
   localparam logic [3:0] control_addr       = 4'h4;
   localparam logic [3:0] protection_key_addr = 4'h8;
   localparam logic [3:0] destination_addr   = 4'hc;
   localparam logic [3:0] status_addr        = 4'h0;

   localparam logic [7:0] boot_array_key     = 8'haa;
   localparam logic [7:0] array_select_rst   = 8'h00;
   localparam logic [7:0] download_key       = 8'ha5;

   // Control register field positions
   localparam int         start_bit_pos      = 0;
   // Status word field positions (control register read)
   localparam int         busy_pos           = 0;
   localparam int         boot_sel_pos       = 1;
   localparam int         prog_ok_pos        = 2;

   // Count at which a busy download completes; busy lasts 9 cycles (count 0 to 8)
   localparam logic [3:0] download_cycles    = 4'h8;

   typedef enum logic [1:0] {
      mode_user_program = 2'b00,
      mode_user_boot    = 2'b01,
      mode_boot         = 2'b10,
      mode_programmer   = 2'b11
   } op_mode_e;

   typedef enum logic [0:0] {
      dl_idle = 1'b0,
      dl_busy = 1'b1
   } dl_state_e;
endpackage

// file: inc/reg_write_if.sv
`timescale 1ns/10ps
interface reg_write_if;
   logic       wr_en;
   logic [3:0] addr;
   logic [7:0] data;
   logic       ram_exec;
   modport bus  (output wr_en, output addr, output data, output ram_exec);
   modport core (input wr_en, input addr, input data, input ram_exec);
endinterface

// file: src/download_ctrl.sv
`timescale 1ns/10ps
module download_ctrl (
   input  wire logic sys_clk,
   input  wire logic rstn,
   reg_write_if.core wr,
   output logic      start_reg,
   output logic [7:0] key_reg,
   output logic [7:0] dest_reg
);
   import flash_array_pkg::*;

   dl_state_e  state_reg;
   dl_state_e  state_next;
   logic [3:0] count_reg;
   logic [3:0] count_next;
   logic [7:0] key_next;
   logic [7:0] dest_next;
   wire        key_wr;
   wire        dest_wr;
   wire        start_req;
   wire        done;

   assign key_wr    = wr.wr_en && (wr.addr == protection_key_addr);
   assign dest_wr   = wr.wr_en && (wr.addr == destination_addr);
   // Start honoured only with the key in place and from RAM
   assign start_req = wr.wr_en && (wr.addr == control_addr)
                      && wr.data[start_bit_pos]
                      && (key_reg == download_key) && wr.ram_exec;
   assign done      = (state_reg == dl_busy) && (count_reg == download_cycles);

   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      unique case (state_reg)
         dl_idle: begin
            count_next = 4'h0;
            if (start_req) begin
               state_next = dl_busy;
            end
         end
         dl_busy: begin
            count_next = count_reg + 4'h1;
            if (done) begin
               state_next = dl_idle;
            end
         end
      endcase
   end

   assign key_next  = key_wr ? wr.data : key_reg;
   assign dest_next = dest_wr ? wr.data : dest_reg;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state_reg <= dl_idle;
         count_reg <= 4'h0;
         key_reg   <= 8'h00;
         dest_reg  <= 8'h00;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         key_reg   <= key_next;
         dest_reg  <= dest_next;
      end
   end

   // Destination latched as written; software sets it before start
   assign start_reg = (state_reg == dl_busy);
endmodule

// file: src/flash_array_select.sv
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/10ps
module flash_array_select (
   input  wire logic                       sys_clk,
   input  wire logic                       rstn,
   input  wire flash_array_pkg::op_mode_e  op_mode,
   input  wire logic                       ram_exec,
   input  wire logic                       prog_req,
   input  wire logic [3:0]                 avs_address,
   input  wire logic                       avs_read,
   input  wire logic                       avs_write,
   input  wire logic [31:0]                avs_writedata,
   input  wire logic [3:0]                 avs_byteenable,
   output logic [31:0]                     avs_readdata,
   output logic                            avs_waitrequest,
   output logic                            boot_array_sel,
   output logic                            prog_enable,
   output logic                            download_busy,
   output logic [7:0]                      download_destination
);
   import flash_array_pkg::*;

   reg_write_if wr ();

   logic [7:0]  flash_array_select_reg;
   logic [7:0]  flash_array_select_next;
   logic        init_reg;
   logic        ack_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [7:0]  key_reg;
   logic        start_reg;
   wire         access;
   wire         sel_wr;
   wire         lane0;
   wire         boot_sel;
   wire [7:0]   status_word;

   // One wait cycle per access; a write acts only at the edge where the
   // master sees waitrequest low, so both sides agree on the moment
   assign access          = (avs_read || avs_write) && !ack_reg;
   assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
   assign lane0           = avs_byteenable[0];

   assign wr.wr_en    = avs_write && ack_reg && lane0;
   assign wr.addr     = avs_address;
   assign wr.data     = avs_writedata[7:0];
   assign wr.ram_exec = ram_exec;

   // Non-RAM writes fall through and keep the old value
   assign sel_wr = wr.wr_en && (avs_address == array_select_addr)
                   && ram_exec;
   assign flash_array_select_next = sel_wr ? wr.data
                                           : flash_array_select_reg;

   assign boot_sel = (flash_array_select_reg == boot_array_key);

   // User boot array only programmable in boot or programmer mode
   assign prog_enable = prog_req
                        && (!boot_sel || op_mode == mode_boot
                            || op_mode == mode_programmer);

   assign status_word = {5'h00, prog_enable, boot_sel, start_reg};

   always_comb begin
      rdata_next = 32'h0000_0000;
      unique case (avs_address)
         array_select_addr:  rdata_next = {24'h0, flash_array_select_reg};
         control_addr:       rdata_next = {24'h0, status_word};
         protection_key_addr: rdata_next = {24'h0, key_reg};
         destination_addr:   rdata_next = {24'h0, download_destination};
         default:            rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         ack_reg   <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         ack_reg   <= access;
         rdata_reg <= (access && avs_read) ? rdata_next : rdata_reg;
      end
   end

   // Mode is sampled at the first clock after reset release, not in reset
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         init_reg               <= 1'b1;
         flash_array_select_reg <= array_select_rst;
      end else if (init_reg) begin
         init_reg               <= 1'b0;
         flash_array_select_reg <= (op_mode == mode_user_boot)
                                   ? boot_array_key
                                   : array_select_rst;
      end else begin
         flash_array_select_reg <= flash_array_select_next;
      end
   end

   download_ctrl u_download_ctrl (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .wr        (wr.core),
      .start_reg (start_reg),
      .key_reg   (key_reg),
      .dest_reg  (download_destination)
   );

   assign avs_readdata   = rdata_reg;
   assign boot_array_sel = boot_sel;
   assign download_busy  = start_reg;
endmodule

// file: testbench/flash_array_select_sva.sv
`timescale 1ns/10ps
module flash_array_select_sva
   import flash_array_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rstn,
   input wire op_mode_e    op_mode,
   input wire logic        ram_exec,
   input wire logic        prog_req,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        boot_array_sel,
   input wire logic        prog_enable,
   input wire logic        download_busy,
   input wire logic [7:0]  download_destination
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   wire done = avs_write && !avs_waitrequest && avs_byteenable[0];
   a_sel_key: assert property (done && avs_address == 4'h0 && ram_exec
      |=> boot_array_sel == ($past(avs_writedata[7:0]) == 8'haa))
      else $error("select does not follow written key");
   a_sel_kept: assert property (avs_write && avs_address == 4'h0
      && !ram_exec |=> $stable(boot_array_sel))
      else $error("select changed by write outside RAM");
   a_reset_boot: assert property ($rose(rstn)
      && op_mode == mode_user_boot |=> boot_array_sel)
      else $error("boot array not selected after reset");
   a_reset_user: assert property ($rose(rstn)
      && op_mode != mode_user_boot |=> !boot_array_sel)
      else $error("user array not selected after reset");
   a_user_block: assert property (op_mode == mode_user_program
      && boot_array_sel |-> !prog_enable)
      else $error("boot array programmable in user program mode");
   a_boot_prog: assert property (prog_req && op_mode[1] |-> prog_enable)
      else $error("programming refused in boot or programmer mode");
   a_start_ram: assert property (avs_write && avs_address == 4'h4
      && !ram_exec && !download_busy |=> !download_busy)
      else $error("download started outside RAM");
   a_busy_len: assert property ($rose(download_busy)
      |=> download_busy [*8] ##1 !download_busy)
      else $error("download length wrong");
   a_dest_wr: assert property (done && avs_address == 4'hc
      |=> download_destination == $past(avs_writedata[7:0]))
      else $error("destination not stored");
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest)
      else $error("more than one wait cycle");
endmodule
bind flash_array_select flash_array_select_sva chk_i (.*);

// file: testbench/flash_array_select_tb_top.sv
`timescale 1ns/10ps
module flash_array_select_tb_top;
   import flash_array_pkg::*;
   logic sys_clk, rstn, ram_exec, prog_req, avs_read, avs_write;
   logic sel, prog_enable, download_busy, avs_waitrequest;
   op_mode_e op_mode;
   logic [3:0] avs_address;
   logic [3:0] be;
   logic [7:0] dest;
   logic [31:0] avs_writedata, avs_readdata, q;
   int mismatches, n_compared, cycles;
   flash_array_select uut (.sys_clk(sys_clk), .rstn(rstn),
      .op_mode(op_mode), .ram_exec(ram_exec), .prog_req(prog_req),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(be), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .boot_array_sel(sel),
      .prog_enable(prog_enable), .download_busy(download_busy),
      .download_destination(dest));
   initial begin
      sys_clk = 0;
      forever #10 sys_clk = ~sys_clk;
   end
   task end_of_test;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         end_of_test;
      end
   end
   task chk(input string nm, input logic [31:0] s, e);
      n_compared++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Request held until the rising edge that sees waitrequest low
   task xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
   endtask
   task rst(input op_mode_e m);
      @(posedge sys_clk);
      op_mode <= m;
      rstn <= 0;
      repeat (5) @(posedge sys_clk);
      rstn <= 1;
      @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   initial begin
      {rstn, ram_exec, prog_req, avs_read, avs_write} = 5'h08;
      {avs_address, avs_writedata, cycles} = 0;
      be = 4'hf;
      op_mode = mode_user_program;
      rst(mode_user_program);
      chk("sel", sel, 0);
      xfer(0, 4'h0, 0);
      chk("sel_rd", q, 32'h0);
      xfer(1, 4'h0, 32'haa);
      @(negedge sys_clk) chk("sel", sel, 1);
      xfer(0, 4'h0, 0);
      chk("sel_rd", q, 32'haa);
      ram_exec <= 0;
      xfer(1, 4'h0, 32'h0);
      xfer(0, 4'h0, 0);
      chk("sel_rd", q, 32'haa);
      @(posedge sys_clk) prog_req <= 1;
      @(negedge sys_clk) chk("prog", prog_enable, 0);
      @(posedge sys_clk) op_mode <= mode_boot;
      @(negedge sys_clk) chk("prog", prog_enable, 1);
      @(posedge sys_clk) op_mode <= mode_programmer;
      @(negedge sys_clk) chk("prog", prog_enable, 1);
      $display("test select and program done");
      @(posedge sys_clk) ram_exec <= 1;
      xfer(1, 4'hc, 32'h3);
      xfer(1, 4'h4, 32'h1);
      @(negedge sys_clk) chk("busy", download_busy, 0);
      xfer(1, 4'h8, 32'ha5);
      xfer(1, 4'h4, 32'h1);
      @(negedge sys_clk) chk("busy", download_busy, 1);
      repeat (12) @(negedge sys_clk);
      chk("busy", download_busy, 0);
      chk("dest", dest, 8'h03);
      xfer(0, 4'h1, 0);
      chk("unmapped", q, 32'h0);
      xfer(1, 4'h0, 32'hab);
      @(negedge sys_clk) chk("sel", sel, 0);
      @(posedge sys_clk) be <= 4'he;
      xfer(1, 4'h0, 32'haa);
      @(negedge sys_clk) chk("sel_be", sel, 0);
      @(posedge sys_clk) be <= 4'hf;
      $display("test download done");
      rst(mode_user_boot);
      chk("sel", sel, 1);
      xfer(0, 4'h0, 0);
      chk("sel_rd", q, 32'haa);
      $display("test boot reset done");
      end_of_test;
   end
endmodule
